// >>> dv/link_setup_sva.sv
// Port checker for the link setup block
`timescale 1ns/1ps
module link_setup_sva (
    input logic SYS_CLK,
    input logic RESET_N,
    input logic S_AXI_AWVALID,
    input logic S_AXI_AWREADY,
    input logic S_AXI_WVALID,
    input logic S_AXI_WREADY,
    input logic S_AXI_BVALID,
    input logic S_AXI_BREADY,
    input logic S_AXI_ARVALID,
    input logic S_AXI_ARREADY,
    input logic S_AXI_RVALID,
    input logic S_AXI_RREADY,
    input logic PHY_LINK,
    input logic AUTONEG_DONE_FLAG,
    input logic SIGNAL_LOST_IND,
    input logic LINK_UP_STATUS,
    input logic RX_FLOW_CTL_ENABLE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_wr_take;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence s_wr_resp;
        !S_AXI_BVALID ##1 S_AXI_BVALID;
    endsequence
    property p_wresp; s_wr_take |=> s_wr_resp; endproperty
    property p_bhold; $fell(S_AXI_BVALID) |-> $past(S_AXI_BREADY); endproperty
    property p_rhold; $fell(S_AXI_RVALID) |-> $past(S_AXI_RREADY); endproperty
    property p_wbusy; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
    property p_arbusy; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
    property p_rresp; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
    // Link-up can only rise from some qualifying indication one cycle earlier
    property p_luup;
        $rose(LINK_UP_STATUS) |-> $past(PHY_LINK) || $past(AUTONEG_DONE_FLAG)
            || !$past(SIGNAL_LOST_IND);
    endproperty
    property p_fc; $changed(RX_FLOW_CTL_ENABLE) |-> $rose(S_AXI_BVALID); endproperty
    a_wresp: assert property (p_wresp) else $error("write answer timing wrong");
    a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
    a_rhold: assert property (p_rhold) else $error("rvalid dropped early");
    a_wbusy: assert property (p_wbusy) else $error("write ready while answering");
    a_arbusy: assert property (p_arbusy) else $error("read ready while answering");
    a_rresp: assert property (p_rresp) else $error("read answer late");
    a_luup: assert property (p_luup) else $error("link up without cause");
    a_fc: assert property (p_fc) else $error("flow enable moved without write");
endmodule

// >>> dv/link_setup_test.sv
// Self-checking bench for link setup resolution
`timescale 1ns/1ps
`include "link_setup_map.vh"
module link_setup_test;
    logic        sys_clk = 1'h0;
    logic        reset_n = 1'h0;
    logic        awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, d;
    wire         awready, wready, bvalid, arready, rvalid, lnk, dpx, an_done, sig_lost;
    wire         lu_st, dpx_st, rx_fc, tx_fc, f_link, f_sd, f_lv, f_dv;
    wire  [1:0]  bresp, rresp, spd_st, forced_speed_value, phy_spd, sg_spd;
    wire  [31:0] rdata;
    wire  [15:0] ability;
    int          num_errors = 0;
    int          n_compared = 0;
    logic [31:0] rst_tab [4] = '{32'h0, 32'h0, 32'h0, 32'h60};
    always #5 sys_clk = ~sys_clk;
    link_setup i_link_setup (.SYS_CLK(sys_clk), .RESET_N(reset_n),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'h1),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'h1),
        .PHY_LINK(lnk), .PHY_DUPLEX_INDICATION(dpx), .PHY_SPEED_INDICATION(phy_spd),
        .AUTONEG_DONE_FLAG(an_done), .PARTNER_ABILITY_REG(ability), .SIGNAL_LOST_IND(sig_lost),
        .SGMII_SPEED_INDICATION(sg_spd), .LINK_UP_STATUS(lu_st), .DUPLEX_STATUS(dpx_st),
        .SPEED_STATUS(spd_st), .RX_FLOW_CTL_ENABLE(rx_fc), .TX_FLOW_CTL_ENABLE(tx_fc),
        .PCS_FORCE_LINK(f_link), .FORCED_SIGNAL_DETECT(f_sd), .FORCED_LINK_VALUE(f_lv),
        .FORCED_DUPLEX_VALUE(f_dv), .FORCED_SPEED_VALUE(forced_speed_value));
    phy_pcs_model i_phy_pcs_model (.sys_clk(sys_clk), .link(lnk), .duplex(dpx),
        .speed(phy_spd), .an_done(an_done), .ability(ability), .sig_lost(sig_lost),
        .sg_speed(sg_spd));
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        int n = 0;
        awaddr <= a; wdata <= v; awvalid <= 1'h1; wvalid <= 1'h1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            n++;
        end while (bvalid !== 1'h1 && n < 50);
        chk("write answer", {bvalid, bresp}, {1'h1, `RESP_OKAY});
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        int n = 0;
        araddr <= a; arvalid <= 1'h1;
        do begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'h0;
            n++;
        end while (rvalid !== 1'h1 && n < 50);
        v = rdata;
        chk("read answer", {rvalid, rresp}, {1'h1, `RESP_OKAY});
    endtask
    // Status register and pins must agree; fields speed[3:2], link[1], duplex[0]
    task automatic st(input logic [3:0] e);
        repeat (3) @(posedge sys_clk);
        rd(`STAT_OFS, d);
        chk("status reg", d, {28'h0, e});
        chk("status pins", {spd_st, lu_st, dpx_st}, e);
    endtask
    task automatic scen(input string nm, input logic [31:0] ctl, lct, input logic [8:0] p,
                        input logic [3:0] e);
        i_phy_pcs_model.set(p);
        wr(`LCTL_OFS, lct);
        wr(`CTRL_OFS, ctl);
        st(e);
        $display("test %s done", nm);
    endtask
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #200us;
        num_errors++;
        complete_run();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'h1;
        @(posedge sys_clk);
        for (int i = 0; i < 4; i++) begin
            rd(4'(i * 4), d);
            chk("reset value", d, rst_tab[i]);
        end
        scen("int auto", 32'h32, 32'h0, 9'h1A4, 4'h7);
        chk("flow enables", {tx_fc, rx_fc}, 2'h3);
        scen("int no slu", 32'h30, 32'h0, 9'h1A4, 4'h5);
        scen("int forced", 32'hCE, 32'h0, 9'h1A4, 4'hE);
        scen("serdes an", 32'h340, 32'h3F, 9'h01C, 4'hB);
        chk("gated forces", {f_link, f_sd, f_lv, f_dv, forced_speed_value}, 6'h1);
        scen("serdes an half", 32'h340, 32'h3F, 9'h014, 4'hA);
        scen("serdes sw", 32'h343, 32'h3E, 9'h000, 4'hB);
        chk("pcs forces", {f_link, f_sd, f_lv, f_dv}, 4'hF);
        scen("serdes los", 32'h343, 32'h3E, 9'h004, 4'h9);
        scen("sgmii an", 32'h200, 32'h1, 9'h01D, 4'h7);
        scen("sgmii forced", 32'h2CF, 32'h7E, 9'h000, 4'hF);
        chk("forced speed", forced_speed_value, 2'h3);
        wr(`STAT_OFS, 32'h0);
        st(4'hF);
        $display("test status read only done");
        complete_run();
    end
endmodule
bind link_setup link_setup_sva i_link_setup_sva (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .PHY_LINK(PHY_LINK),
    .AUTONEG_DONE_FLAG(AUTONEG_DONE_FLAG), .SIGNAL_LOST_IND(SIGNAL_LOST_IND),
    .LINK_UP_STATUS(LINK_UP_STATUS), .RX_FLOW_CTL_ENABLE(RX_FLOW_CTL_ENABLE));

// >>> dv/phy_pcs_model.sv
// Behavioural PHY and PCS partner driving the link indications
`timescale 1ns/1ps
module phy_pcs_model (
    input  logic        sys_clk,
    output logic        link     = 1'h0,
    output logic        duplex   = 1'h0,
    output logic [1:0]  speed    = 2'h0,
    output logic        an_done  = 1'h0,
    output logic [15:0] ability  = 16'h0,
    output logic        sig_lost = 1'h1,
    output logic [1:0]  sg_speed = 2'h0
);
    // Packed: link, duplex, speed[1:0], an done, full-duplex ability, signal lost, sgmii speed
    task automatic set(input logic [8:0] p);
        @(posedge sys_clk);
        {link, duplex, speed, an_done} <= p[8:4];
        ability <= {10'h0, p[3], 5'h0};
        {sig_lost, sg_speed} <= p[2:0];
    endtask
endmodule

// >>> logic/link_setup.v
// Link setup resolution: duplex, speed and link-up from controls and PHY/PCS inputs
// Functional notes
// - Link mode 11b selects external SerDes link setup.
// - Link mode 10b selects external SGMII link setup.
// - Internal PHY unforced: duplex comes from PHY indication, software bit ignored.
// - Internal PHY unforced: speed comes from PHY indication and is reported.
// - Internal PHY forced: status shows software duplex and speed values.
// - Internal PHY: link-up is PHY link AND set-link-up control.
// - Fully forced: link-up shows 1 from set-link-up and forced link, unverified. Code: set-link-up AND no signal loss; forced link unused.
// - SerDes/SGMII autoneg: duplex from priority resolution of advert vs partner.
// - Autoneg on: set-link-up and PCS force controls are ignored. FORCED_SPEED_VALUE is still driven out ungated.
// - Autoneg on: status duplex shows resolved duplex.
// - SerDes autoneg: link-up follows autoneg-complete flag.
// - SerDes: speed always 1000, status speed code 10b.
// - SerDes: control speed and forced speed value ignored.
// - Autoneg off: link-up needs no signal loss and set-link-up.
// - Autoneg off: status duplex shows control duplex bit.
// - SGMII autoneg: speed from SGMII indication after link-up.
// - Forced SGMII: status speed shows control speed field.
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "link_setup_map.vh"
module link_setup (
    input  wire        SYS_CLK,
    input  wire        RESET_N,
    input  wire [3:0]  S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output wire        S_AXI_AWREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output wire        S_AXI_WREADY,
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    input  wire [3:0]  S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output wire        S_AXI_ARREADY,
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY,
    input  wire        PHY_LINK,
    input  wire        PHY_DUPLEX_INDICATION,
    input  wire [1:0]  PHY_SPEED_INDICATION,
    input  wire        AUTONEG_DONE_FLAG,
    input  wire [15:0] PARTNER_ABILITY_REG,
    input  wire        SIGNAL_LOST_IND,
    input  wire [1:0]  SGMII_SPEED_INDICATION,
    output reg         LINK_UP_STATUS,
    output reg         DUPLEX_STATUS,
    output reg  [1:0]  SPEED_STATUS,
    output wire        RX_FLOW_CTL_ENABLE,
    output wire        TX_FLOW_CTL_ENABLE,
    output wire        PCS_FORCE_LINK,
    output wire        FORCED_SIGNAL_DETECT,
    output wire        FORCED_LINK_VALUE,
    output wire        FORCED_DUPLEX_VALUE,
    output wire [1:0]  FORCED_SPEED_VALUE
);

    reg  [9:0]  ctrl_r;
    reg  [6:0]  lctl_r;
    reg  [15:0] local_advert_reg_r;
    reg  [3:0]  awaddr_r;
    reg  [31:0] wdata_r;
    reg  [3:0]  wstrb_r;
    reg         aw_held_r;
    reg         w_held_r;

    reg         link_nxt;
    reg         duplex_nxt;
    reg  [1:0]  speed_nxt;
    reg         an_duplex;

    wire        full_duplex_bit  = ctrl_r[`CTRL_FD_BIT];
    wire        set_link_up_ctl  = ctrl_r[`CTRL_LINKUP_BIT];
    wire        force_speed_ctl  = ctrl_r[`CTRL_FSPEED_BIT];
    wire        force_duplex_ctl = ctrl_r[`CTRL_FDUPLEX_BIT];
    wire [1:0]  ctrl_speed       = ctrl_r[`CTRL_SPD_LSB +: 2];
    wire [1:0]  link_mode        = ctrl_r[`CTRL_MODE_LSB +: 2];
    wire        hw_autoneg_on    = lctl_r[`LCTL_AN_BIT];

    assign RX_FLOW_CTL_ENABLE   = ctrl_r[`CTRL_RXFC_BIT];
    assign TX_FLOW_CTL_ENABLE   = ctrl_r[`CTRL_TXFC_BIT];
    // PCS force controls reach the PCS only when autoneg is off
    assign PCS_FORCE_LINK       = lctl_r[`LCTL_FLINK_BIT] & ~hw_autoneg_on;
    assign FORCED_SIGNAL_DETECT = lctl_r[`LCTL_FSIG_BIT] & ~hw_autoneg_on;
    assign FORCED_LINK_VALUE    = lctl_r[`LCTL_FLINKV_BIT] & ~hw_autoneg_on;
    assign FORCED_DUPLEX_VALUE  = lctl_r[`LCTL_FDUPV_BIT] & ~hw_autoneg_on;
    // Passed through ungated; status never uses it, so it is ignored inside
    assign FORCED_SPEED_VALUE   = lctl_r[`LCTL_FSPDV_LSB +: 2];

    // Priority resolution: full duplex preferred when both ends offer it
    always @* begin
        an_duplex = local_advert_reg_r[`ADV_FD_BIT] & PARTNER_ABILITY_REG[`ADV_FD_BIT];
    end

    always @* begin
        link_nxt   = 1'b0;
        duplex_nxt = full_duplex_bit;
        speed_nxt  = ctrl_speed;
        if (link_mode == `MODE_SERDES || link_mode == `MODE_SGMII) begin
            if (hw_autoneg_on) begin
                duplex_nxt = an_duplex;
                if (link_mode == `MODE_SERDES) begin
                    link_nxt = AUTONEG_DONE_FLAG;
                end else begin
                    link_nxt = AUTONEG_DONE_FLAG;
                    // Speed held at last setting until SGMII link is up
                    speed_nxt = AUTONEG_DONE_FLAG ? SGMII_SPEED_INDICATION : SPEED_STATUS;
                end
            end else begin
                link_nxt   = ~SIGNAL_LOST_IND & set_link_up_ctl;
                duplex_nxt = full_duplex_bit;
                speed_nxt  = ctrl_speed;
            end
            if (link_mode == `MODE_SERDES) begin
                speed_nxt = `SPEED_1000;
            end
        end else begin
            // Internal PHY; forced link shows up unchecked when PHY forces its link
            link_nxt = PHY_LINK & set_link_up_ctl;
            if (force_duplex_ctl) begin
                duplex_nxt = full_duplex_bit;
            end else if (PHY_LINK) begin
                duplex_nxt = PHY_DUPLEX_INDICATION;
            end else begin
                duplex_nxt = DUPLEX_STATUS;
            end
            if (force_speed_ctl) begin
                speed_nxt = ctrl_speed;
            end else if (PHY_LINK) begin
                speed_nxt = PHY_SPEED_INDICATION;
            end else begin
                speed_nxt = SPEED_STATUS;
            end
        end
    end

    always @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            LINK_UP_STATUS <= 1'b0;
            DUPLEX_STATUS  <= 1'b0;
            SPEED_STATUS   <= 2'h0;
        end else begin
            LINK_UP_STATUS <= link_nxt;
            DUPLEX_STATUS  <= duplex_nxt;
            SPEED_STATUS   <= speed_nxt;
        end
    end

    // AXI4-Lite slave: address and data latched separately, then one write
    wire do_write = aw_held_r & w_held_r & ~S_AXI_BVALID;
    assign S_AXI_AWREADY = ~aw_held_r & ~S_AXI_BVALID;
    assign S_AXI_WREADY  = ~w_held_r & ~S_AXI_BVALID;
    assign S_AXI_ARREADY = ~S_AXI_RVALID;

    always @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            ctrl_r             <= `CTRL_RESET;
            lctl_r             <= `LCTL_RESET;
            local_advert_reg_r <= `ADV_RESET;
            awaddr_r           <= 4'h0;
            wdata_r            <= 32'h00000000;
            wstrb_r            <= 4'h0;
            aw_held_r          <= 1'b0;
            w_held_r           <= 1'b0;
            S_AXI_BVALID       <= 1'b0;
            S_AXI_BRESP        <= `RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                awaddr_r  <= S_AXI_AWADDR;
                aw_held_r <= 1'b1;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                wdata_r  <= S_AXI_WDATA;
                wstrb_r  <= S_AXI_WSTRB;
                w_held_r <= 1'b1;
            end
            if (do_write) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= `RESP_OKAY;
                if (awaddr_r == `CTRL_OFS) begin
                    if (wstrb_r[0]) ctrl_r[7:0] <= wdata_r[7:0];
                    if (wstrb_r[1]) ctrl_r[9:8] <= wdata_r[9:8];
                end else if (awaddr_r == `LCTL_OFS) begin
                    if (wstrb_r[0]) lctl_r <= wdata_r[6:0];
                end else if (awaddr_r == `ADV_OFS) begin
                    if (wstrb_r[0]) local_advert_reg_r[7:0] <= wdata_r[7:0];
                    if (wstrb_r[1]) local_advert_reg_r[15:8] <= wdata_r[15:8];
                end else if (awaddr_r != `STAT_OFS) begin
                    S_AXI_BRESP <= `RESP_SLVERR;
                end
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    always @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h00000000;
            S_AXI_RRESP  <= `RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP  <= `RESP_OKAY;
            if (S_AXI_ARADDR == `CTRL_OFS) begin
                S_AXI_RDATA <= {22'h000000, ctrl_r};
            end else if (S_AXI_ARADDR == `LCTL_OFS) begin
                S_AXI_RDATA <= {25'h0000000, lctl_r};
            end else if (S_AXI_ARADDR == `STAT_OFS) begin
                S_AXI_RDATA <= {28'h0000000, SPEED_STATUS, LINK_UP_STATUS, DUPLEX_STATUS};
            end else if (S_AXI_ARADDR == `ADV_OFS) begin
                S_AXI_RDATA <= {16'h0000, local_advert_reg_r};
            end else begin
                S_AXI_RDATA <= 32'h00000000;
                S_AXI_RRESP <= `RESP_SLVERR;
            end
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

endmodule

// >>> logic/link_setup_map.vh
// Register offsets, field positions and reset values of the link setup block
`ifndef LINK_SETUP_MAP_VH
`define LINK_SETUP_MAP_VH
`define CTRL_OFS        4'h0
`define LCTL_OFS        4'h4
`define STAT_OFS        4'h8
`define ADV_OFS         4'hC
`define MODE_INT_PHY    2'h0
`define MODE_SGMII      2'h2
`define MODE_SERDES     2'h3
`define SPEED_1000      2'h2
`define CTRL_FD_BIT     0
`define CTRL_LINKUP_BIT  1
`define CTRL_FSPEED_BIT  2
`define CTRL_FDUPLEX_BIT 3
`define CTRL_RXFC_BIT    4
`define CTRL_TXFC_BIT    5
`define CTRL_SPD_LSB    6
`define CTRL_MODE_LSB   8
`define LCTL_AN_BIT     0
`define LCTL_FLINK_BIT  1
`define LCTL_FSIG_BIT   2
`define LCTL_FLINKV_BIT 3
`define LCTL_FDUPV_BIT  4
`define LCTL_FSPDV_LSB  5
`define ADV_FD_BIT      5
`define ADV_HD_BIT      6
`define CTRL_RESET      10'h000
`define LCTL_RESET      7'h00
`define ADV_RESET       16'h0060
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif
